// ==== include/vlfc_defines.svh ====
// constants for the valley lockout and foldback scheduler
`ifndef VLFC_DEFINES_SVH
`define VLFC_DEFINES_SVH
// feedback thresholds in mV, falling direction
`define VLFC_FALL_V1   12'h578
`define VLFC_FALL_V2   12'h4B0
`define VLFC_FALL_V3   12'h44C
`define VLFC_FALL_V4   12'h3E8
`define VLFC_FALL_V5   12'h384
`define VLFC_FF_ENTER  12'h320
// feedback thresholds in mV, rising direction
`define VLFC_FF_EXIT   12'h3E8
`define VLFC_RISE_V6   12'h5DC
`define VLFC_RISE_V5   12'h640
`define VLFC_RISE_V4   12'h6A4
`define VLFC_RISE_V3   12'h708
`define VLFC_RISE_V2   12'h7D0
`define VLFC_ADJ_HYST  12'h0C8
// skip mode thresholds in mV
`define VLFC_SKIP_ON   12'h190
`define VLFC_SKIP_OFF  12'h1C2
// peak setpoint limits in mV
`define VLFC_SET_MIN   12'h0C8
`define VLFC_ILIM1     12'h320
// dead-time zero point in mV
`define VLFC_DEAD_ZERO 12'h190
// valley numbers
`define VLFC_VAL_FIRST 3'h1
`define VLFC_VAL_LAST  3'h6
// timing
`define VLFC_CLK_KHZ   50000
`define VLFC_TOUT_NS   6000
`define VLFC_CLAMP_NS  40000
`define VLFC_DEAD_NS   2000
`define VLFC_TOUT_CYC  (`VLFC_TOUT_NS * `VLFC_CLK_KHZ / 1000000)
`define VLFC_CLAMP_CYC (`VLFC_CLAMP_NS * `VLFC_CLK_KHZ / 1000000)
`define VLFC_DEAD_CYC  (`VLFC_DEAD_NS * `VLFC_CLK_KHZ / 1000000)
`endif

// ==== include/vlfc_pkg.sv ====
// types for the valley lockout and foldback scheduler
package vlfc_pkg;
  typedef logic [11:0] vlfc_mv_t;
  typedef logic signed [11:0] vlfc_smv_t;
  typedef struct packed {
    logic [2:0] valley;
    logic       foldback;
    logic       skip;
  } vlfc_mode_s;
  typedef enum logic {VLFC_CYC_VALLEY, VLFC_CYC_DEAD} vlfc_cyc_e;
endpackage : vlfc_pkg

// ==== design/vlfc_valley_sel.sv ====
// valley selection with hysteresis, foldback and skip detection
`timescale 1ns/1ps
`include "vlfc_defines.svh"
module vlfc_valley_sel (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire vlfc_pkg::vlfc_mv_t  fb,
  input  wire vlfc_pkg::vlfc_mv_t  adj,
  input  wire logic                adj_en,
  output vlfc_pkg::vlfc_mode_s     mode_q
);
  import vlfc_pkg::*;

  // falling threshold that moves valley v to v+1
  function automatic vlfc_mv_t fall_th(input logic [2:0] v);
    unique case (v)
      3'h1:    fall_th = `VLFC_FALL_V1;
      3'h2:    fall_th = `VLFC_FALL_V2;
      3'h3:    fall_th = `VLFC_FALL_V3;
      3'h4:    fall_th = `VLFC_FALL_V4;
      default: fall_th = `VLFC_FALL_V5;
    endcase
  endfunction : fall_th

  // rising threshold that moves valley v to v-1
  function automatic vlfc_mv_t rise_th(input logic [2:0] v);
    unique case (v)
      3'h6:    rise_th = `VLFC_RISE_V6;
      3'h5:    rise_th = `VLFC_RISE_V5;
      3'h4:    rise_th = `VLFC_RISE_V4;
      3'h3:    rise_th = `VLFC_RISE_V3;
      default: rise_th = `VLFC_RISE_V2;
    endcase
  endfunction : rise_th

  vlfc_mv_t enter_th;
  vlfc_mv_t exit_th;

  // foldback entry and exit points, fixed or adjustable
  assign enter_th = adj_en ? adj : `VLFC_FF_ENTER;
  assign exit_th  = adj_en ? 12'(adj + `VLFC_ADJ_HYST) : `VLFC_FF_EXIT;

  // one step per clock, the neighbours stay blanked
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q.valley   <= `VLFC_VAL_FIRST;
      mode_q.foldback <= 1'b0;
    end else if (mode_q.foldback) begin
      if (fb > exit_th) begin
        mode_q.foldback <= 1'b0;
        mode_q.valley   <= `VLFC_VAL_LAST;
      end
    end else if (mode_q.valley == `VLFC_VAL_LAST) begin
      if (fb < enter_th) begin
        mode_q.foldback <= 1'b1;
      end else if (fb >= rise_th(mode_q.valley)) begin
        mode_q.valley <= 3'(mode_q.valley - 3'h1);
      end
    end else if (fb < fall_th(mode_q.valley)) begin
      mode_q.valley <= 3'(mode_q.valley + 3'h1);
    end else if (mode_q.valley != `VLFC_VAL_FIRST && fb >= rise_th(mode_q.valley)) begin
      mode_q.valley <= 3'(mode_q.valley - 3'h1);
    end
  end

  // skip mode with 50 mV hysteresis
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q.skip <= 1'b1;
    end else if (fb < `VLFC_SKIP_ON) begin
      mode_q.skip <= 1'b1;
    end else if (fb > `VLFC_SKIP_OFF) begin
      mode_q.skip <= 1'b0;
    end
  end

  // valley never jumps by more than one
  valley_one_step_a: assert property (@(posedge clk) disable iff (srst)
    (mode_q.valley - $past(mode_q.valley) <= 3'h1) ||
    ($past(mode_q.valley) - mode_q.valley <= 3'h1))
    else $error("valley moved by more than one step");
  // foldback only from the sixth valley
  ff_entry_six_a: assert property (@(posedge clk) disable iff (srst)
    $rose(mode_q.foldback) |-> $past(mode_q.valley) == `VLFC_VAL_LAST && $past(fb) < $past(enter_th))
    else $error("foldback entered from wrong valley");
  // skip follows the 400 mV threshold
  skip_enter_a: assert property (@(posedge clk) disable iff (srst)
    (fb < `VLFC_SKIP_ON) |=> mode_q.skip)
    else $error("skip not entered below 400 mV");
endmodule : vlfc_valley_sel

// ==== design/vlfc_setpoint.sv ====
// peak current setpoint with floor, freeze and over-power limits
`timescale 1ns/1ps
`include "vlfc_defines.svh"
module vlfc_setpoint (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire vlfc_pkg::vlfc_mv_t  fb,
  input  wire vlfc_pkg::vlfc_mv_t  adj,
  input  wire logic                adj_en,
  input  wire logic                foldback,
  input  wire logic                on_time,
  input  wire vlfc_pkg::vlfc_smv_t overpower_comp_input,
  output vlfc_pkg::vlfc_mv_t       setpt_q
);
  import vlfc_pkg::*;

  logic signed [13:0] opp_sum;
  vlfc_mv_t           setpt_d;

  // fb/4, frozen or floored, then capped by the over-power limits
  always_comb begin
    opp_sum = 14'(signed'({2'b00, `VLFC_ILIM1})) + 14'(overpower_comp_input);
    setpt_d = {2'b00, fb[11:2]};
    if (foldback && adj_en) begin
      setpt_d = {2'b00, adj[11:2]};
    end else if (setpt_d < `VLFC_SET_MIN) begin
      setpt_d = `VLFC_SET_MIN;
    end
    if (on_time && opp_sum < 14'sd0) begin
      setpt_d = 12'h000;
    end else if (on_time && opp_sum < 14'(signed'({2'b00, setpt_d}))) begin
      setpt_d = opp_sum[11:0];
    end
    if (setpt_d > `VLFC_ILIM1) begin
      setpt_d = `VLFC_ILIM1;
    end
  end

  // registered setpoint
  always_ff @(posedge clk) begin
    if (srst) begin
      setpt_q <= `VLFC_SET_MIN;
    end else begin
      setpt_q <= setpt_d;
    end
  end

  // independent 0.8 V cap
  set_cap_a: assert property (@(posedge clk) disable iff (srst)
    setpt_q <= `VLFC_ILIM1)
    else $error("setpoint above 0.8 V");
  // floor holds outside the on-time and the adjustable foldback freeze
  set_floor_a: assert property (@(posedge clk) disable iff (srst)
    !on_time && !(foldback && adj_en) |=> setpt_q >= `VLFC_SET_MIN)
    else $error("setpoint below 0.2 V floor");
endmodule : vlfc_setpoint

// ==== design/vlfc_sched.sv ====
// switching cycle scheduler: valley counting, foldback dead-time,
// 25 kHz clamp and skip
// Functional notes
// - pick one valley, first to sixth, from the feedback level.
// - each detected valley advances the valley counter by one; the code holds the counter at six and clears it on a new pulse.
// - a newly active valley comparator blanks its neighbour.
// - hold the valley until the lower or upper threshold is crossed.
// - falling steps at 1.4, 1.2, 1.1, 1.0, 0.9 V; foldback at 0.8 V.
// - rising: foldback to sixth at 1.0 V, then 1.5 to 2.0 V.
// - fixed variant enters foldback from sixth valley below 0.8 V.
// - peak setpoint never below 0.2 V; the code skips this floor for the frozen quarter and the on-time limit.
// - fixed variant leaves foldback above 1 V.
// - adjustable variant uses its level, freezes setpoint at a quarter.
// - in foldback add dead-time after the sixth valley.
// - dead-time 2 us at 0.8 V, unbounded toward 0.4 V.
// - a cycle longer than 40 us forces a new cycle.
// - the clamp waits for demagnetization to finish.
// - stop pulsing below 400 mV, resume above 450 mV.
// - on-time limit is primary limit plus negative compensation.
// - setpoint capped at 0.8 V whatever the compensation input.
// - an expired timeout counts as a valley.
`timescale 1ns/1ps
`include "vlfc_defines.svh"
module vlfc_sched (
  input  wire logic                CLK,
  input  wire logic                SRST,
  input  wire vlfc_pkg::vlfc_mv_t  FEEDBACK_LEVEL,
  input  wire vlfc_pkg::vlfc_mv_t  FOLDBACK_ADJUST_LEVEL,
  input  wire logic                FOLDBACK_ADJUST_INPUT,
  input  wire vlfc_pkg::vlfc_smv_t OVERPOWER_COMP_VOLTAGE,
  input  wire logic                ON_TIME,
  input  wire logic                DEMAG_DETECT,
  input  wire logic                DEMAG_DONE,
  output logic                     GATE_DRIVE_OUT,
  output logic                     VALLEY_LOCK_MODE,
  output logic                     FREQ_FOLDBACK_MODE,
  output logic                     SKIP_ACTIVE,
  output logic [2:0]               SELECTED_VALLEY,
  output vlfc_pkg::vlfc_mv_t       COMPENSATED_PEAK_SETPOINT
);
  import vlfc_pkg::*;

  localparam int TOUT_CYC  = `VLFC_TOUT_CYC;
  localparam int CLAMP_CYC = `VLFC_CLAMP_CYC;
  localparam int DEAD_CYC  = `VLFC_DEAD_CYC;
  localparam logic [8:0]  TOUT_LAST  = 9'(TOUT_CYC - 1);
  localparam logic [11:0] CLAMP_LAST = 12'(CLAMP_CYC - 1);
  // dead-time target: accumulating (fb - 0.4 V) per clock
  localparam logic [16:0] DEAD_TARGET = 17'(DEAD_CYC * int'(`VLFC_DEAD_ZERO));

  vlfc_mode_s  mode_q;
  vlfc_cyc_e   cyc_q;
  logic [11:0] period_q;
  logic [8:0]  tout_q;
  logic [2:0]  vcnt_q;
  logic [16:0] acc_q;
  logic [11:0] dead_step;
  logic        tout_expire;
  logic        valley_event;
  logic        count_reached;
  logic        valley_hit;
  logic        sixth_seen;
  logic        dead_done;
  logic        clamp_hit;
  logic        fire;
  logic        drv_q;

  // valley selection and skip detection
  vlfc_valley_sel u_sel (
    .clk    (CLK),
    .srst   (SRST),
    .fb     (FEEDBACK_LEVEL),
    .adj    (FOLDBACK_ADJUST_LEVEL),
    .adj_en (FOLDBACK_ADJUST_INPUT),
    .mode_q (mode_q)
  );

  // peak current setpoint
  vlfc_setpoint u_set (
    .clk      (CLK),
    .srst     (SRST),
    .fb       (FEEDBACK_LEVEL),
    .adj      (FOLDBACK_ADJUST_LEVEL),
    .adj_en   (FOLDBACK_ADJUST_INPUT),
    .foldback (mode_q.foldback),
    .on_time  (ON_TIME),
    .overpower_comp_input      (OVERPOWER_COMP_VOLTAGE),
    .setpt_q  (COMPENSATED_PEAK_SETPOINT)
  );

  // valley events: detected valley or expired timeout
  assign tout_expire   = (tout_q == TOUT_LAST) && !DEMAG_DETECT;
  assign valley_event  = DEMAG_DETECT || tout_expire;
  assign count_reached = valley_event && (3'(vcnt_q + 3'h1) >= mode_q.valley);

  // pulse on the selected valley in lockout mode
  assign valley_hit = (cyc_q == VLFC_CYC_VALLEY) && !mode_q.foldback
                      && count_reached;

  // sixth valley seen while in foldback starts the dead-time
  assign sixth_seen = (cyc_q == VLFC_CYC_VALLEY) && mode_q.foldback && valley_event
                      && (3'(vcnt_q + 3'h1) >= `VLFC_VAL_LAST);

  // dead-time step shrinks toward zero as feedback nears 0.4 V
  assign dead_step = (FEEDBACK_LEVEL > `VLFC_DEAD_ZERO) ?
                     12'(FEEDBACK_LEVEL - `VLFC_DEAD_ZERO) : 12'h000;
  assign dead_done = (cyc_q == VLFC_CYC_DEAD)
                     && (17'(acc_q + {5'h00, dead_step}) >= DEAD_TARGET);

  // 25 kHz clamp, only once demagnetization is over
  assign clamp_hit = (period_q >= CLAMP_LAST) && DEMAG_DONE;

  // new cycle request, blocked in skip
  assign fire = !mode_q.skip && (valley_hit || dead_done || clamp_hit);

  // switching period counter, saturating
  always_ff @(posedge CLK) begin
    if (SRST) begin
      period_q <= 12'h000;
    end else if (fire) begin
      period_q <= 12'h000;
    end else if (period_q != CLAMP_LAST) begin
      period_q <= 12'(period_q + 12'h001);
    end
  end

  // timeout restarts on each detected valley and on expiry
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tout_q <= 9'h000;
    end else if (fire || valley_event) begin
      tout_q <= 9'h000;
    end else begin
      tout_q <= 9'(tout_q + 9'h001);
    end
  end

  // valley counter, cleared by each new pulse
  always_ff @(posedge CLK) begin
    if (SRST) begin
      vcnt_q <= 3'h0;
    end else if (fire) begin
      vcnt_q <= 3'h0;
    end else if (valley_event && vcnt_q != `VLFC_VAL_LAST) begin
      vcnt_q <= 3'(vcnt_q + 3'h1);
    end
  end

  // cycle phase: counting valleys or waiting out the dead-time
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cyc_q <= VLFC_CYC_VALLEY;
    end else if (fire) begin
      cyc_q <= VLFC_CYC_VALLEY;
    end else begin
      unique case (cyc_q)
        VLFC_CYC_VALLEY: begin
          if (sixth_seen) begin
            cyc_q <= VLFC_CYC_DEAD;
          end
        end
        VLFC_CYC_DEAD: begin
          if (!mode_q.foldback) begin
            cyc_q <= VLFC_CYC_VALLEY;
          end
        end
      endcase
    end
  end

  // dead-time accumulator
  always_ff @(posedge CLK) begin
    if (SRST) begin
      acc_q <= 17'h00000;
    end else if (cyc_q != VLFC_CYC_DEAD || fire) begin
      acc_q <= 17'h00000;
    end else begin
      acc_q <= 17'(acc_q + {5'h00, dead_step});
    end
  end

  // drive request, one clock wide
  always_ff @(posedge CLK) begin
    if (SRST) begin
      drv_q <= 1'b0;
    end else begin
      drv_q <= fire;
    end
  end

  // status outputs
  assign GATE_DRIVE_OUT     = drv_q;
  assign VALLEY_LOCK_MODE   = !mode_q.foldback;
  assign FREQ_FOLDBACK_MODE = mode_q.foldback;
  assign SKIP_ACTIVE        = mode_q.skip;
  assign SELECTED_VALLEY    = mode_q.valley;

  // clamp forces a pulse after 40 us once demagnetized
  clamp_forces_a: assert property (@(posedge CLK) disable iff (SRST)
    (period_q == CLAMP_LAST) && DEMAG_DONE && !mode_q.skip |=> GATE_DRIVE_OUT)
    else $error("clamp did not force a pulse");
  // clamp never fires before demagnetization
  clamp_waits_a: assert property (@(posedge CLK) disable iff (SRST)
    GATE_DRIVE_OUT && $past(period_q) == CLAMP_LAST && !$past(DEMAG_DONE)
    |-> $past(valley_event))
    else $error("clamp pulse during demagnetization");
  // no pulse while skipping
  skip_blocks_a: assert property (@(posedge CLK) disable iff (SRST)
    mode_q.skip |=> !GATE_DRIVE_OUT)
    else $error("pulse issued in skip mode");
  // pulse on selected valley, count cleared after
  valley_pulse_a: assert property (@(posedge CLK) disable iff (SRST)
    !mode_q.skip && !mode_q.foldback && cyc_q == VLFC_CYC_VALLEY && DEMAG_DETECT
    && 3'(vcnt_q + 3'h1) == mode_q.valley |=> GATE_DRIVE_OUT ##1 vcnt_q == 3'h0)
    else $error("valley pulse or count clear missing");
  // expired timeout counts as a valley
  tout_counts_a: assert property (@(posedge CLK) disable iff (SRST)
    tout_expire && !fire && vcnt_q < `VLFC_VAL_LAST |=> vcnt_q == $past(vcnt_q) + 3'h1)
    else $error("timeout not counted as valley");
  // dead-time at or below 0.8 V lasts at least 2 us, so no pulse in its first clocks
  dead_nominal_a: assert property (@(posedge CLK) disable iff (SRST)
    sixth_seen && !fire && !mode_q.skip && FEEDBACK_LEVEL <= `VLFC_FF_ENTER
    ##1 (FEEDBACK_LEVEL <= `VLFC_FF_ENTER && mode_q.foldback && !mode_q.skip
         && period_q != CLAMP_LAST) [*8]
    |-> !GATE_DRIVE_OUT)
    else $error("dead-time too short at 0.8 V");

  // timeout counter wraps at its last count
  tout_bound_a: assert property (@(posedge CLK) disable iff (SRST)
    tout_q <= TOUT_LAST)
    else $error("timeout counter ran past its end");

  // period counter saturates at the clamp point
  period_bound_a: assert property (@(posedge CLK) disable iff (SRST)
    period_q <= CLAMP_LAST)
    else $error("period counter ran past the clamp");

  // valley counter never passes the sixth valley
  vcnt_bound_a: assert property (@(posedge CLK) disable iff (SRST)
    vcnt_q <= `VLFC_VAL_LAST)
    else $error("valley counter above six");

  // selected valley stays within first to sixth
  valley_range_a: assert property (@(posedge CLK) disable iff (SRST)
    SELECTED_VALLEY >= `VLFC_VAL_FIRST && SELECTED_VALLEY <= `VLFC_VAL_LAST)
    else $error("selected valley out of range");

  // foldback is only reported on the sixth valley
  ff_on_six_a: assert property (@(posedge CLK) disable iff (SRST)
    FREQ_FOLDBACK_MODE |-> SELECTED_VALLEY == `VLFC_VAL_LAST)
    else $error("foldback away from the sixth valley");

  // leaving foldback mid dead-time returns to valley counting
  dead_leave_a: assert property (@(posedge CLK) disable iff (SRST)
    cyc_q == VLFC_CYC_DEAD && !mode_q.foldback |=> cyc_q == VLFC_CYC_VALLEY)
    else $error("dead-time kept after foldback exit");

  // accumulator idles at zero outside the dead-time
  acc_clear_a: assert property (@(posedge CLK) disable iff (SRST)
    cyc_q != VLFC_CYC_DEAD |=> acc_q == 17'h00000)
    else $error("dead-time accumulator not cleared");

  c_valley_pulse_c: cover property (@(posedge CLK) disable iff (SRST) valley_hit && !mode_q.skip);
  c_dead_pulse_c:   cover property (@(posedge CLK) disable iff (SRST) dead_done && !mode_q.skip);
  c_clamp_pulse_c:  cover property (@(posedge CLK) disable iff (SRST) clamp_hit && !mode_q.skip);
  c_tout_event_c:   cover property (@(posedge CLK) disable iff (SRST) tout_expire && !mode_q.skip);
  c_ff_exit_c:      cover property (@(posedge CLK) disable iff (SRST) $fell(mode_q.foldback));
endmodule : vlfc_sched

// ==== sim/vlfc_gate_partner.sv ====
// far-side model: gate driver on-time, demagnetization and ringing valleys
`timescale 1ns/1ps
module vlfc_gate_partner #(
  parameter int ON_CYC = 10
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        gate,
  input  wire logic [15:0] dem_cyc,
  input  wire logic [15:0] gap_cyc,
  input  wire logic [15:0] n_valleys,
  output logic             on_time,
  output logic             demag_detect,
  output logic             demag_done
);
  logic [15:0] t_q;
  int          k;

  // time since the last drive pulse, parked at its top while idle
  always_ff @(posedge clk) begin
    if (srst) begin
      t_q <= 16'hFFFF;
    end else if (gate) begin
      t_q <= 16'h0000;
    end else if (t_q != 16'hFFFF) begin
      t_q <= t_q + 16'h0001;
    end
  end

  // switch on, then demagnetize, then ring a limited number of valleys
  assign k            = int'(t_q) - ON_CYC - int'(dem_cyc);
  assign on_time      = (int'(t_q) < ON_CYC);
  assign demag_done   = (k >= 0);
  assign demag_detect = (k > 0) && (k % int'(gap_cyc) == 0)
                        && (k <= int'(n_valleys) * int'(gap_cyc));
endmodule : vlfc_gate_partner

// ==== sim/tb_top.sv ====
// self-checking bench for the valley lockout and foldback scheduler
`timescale 1ns/1ps
`include "vlfc_defines.svh"
module tb_top;
  import vlfc_pkg::*;
  typedef struct packed {
    vlfc_mv_t   fb;
    vlfc_mv_t   adj;
    logic [2:0] v;
    logic       ff;
    logic       sk;
  } vlfc_tb_row_s;
  logic        clk, srst, adj_en, on_time, demag_detect, demag_done;
  logic        gate, lock_mode, ff_mode, skip;
  logic [2:0]  valley;
  vlfc_mv_t    fb, adj, setpt;
  vlfc_smv_t   overpower_comp_input;
  logic [15:0] dem_cyc, gap_cyc, n_val;
  int          mismatches, comparisons, per, nv, since, d, n;
  vlfc_tb_row_s rows [25] = '{
    '{12'h834, 12'h000, 3'h1, 1'b0, 1'b0}, '{12'h578, 12'h000, 3'h1, 1'b0, 1'b0},
    '{12'h577, 12'h000, 3'h2, 1'b0, 1'b0}, '{12'h7CF, 12'h000, 3'h2, 1'b0, 1'b0},
    '{12'h4B0, 12'h000, 3'h2, 1'b0, 1'b0}, '{12'h4AF, 12'h000, 3'h3, 1'b0, 1'b0},
    '{12'h44B, 12'h000, 3'h4, 1'b0, 1'b0}, '{12'h3E7, 12'h000, 3'h5, 1'b0, 1'b0},
    '{12'h383, 12'h000, 3'h6, 1'b0, 1'b0}, '{12'h320, 12'h000, 3'h6, 1'b0, 1'b0},
    '{12'h31F, 12'h000, 3'h6, 1'b1, 1'b0}, '{12'h3E8, 12'h000, 3'h6, 1'b1, 1'b0},
    '{12'h3E9, 12'h000, 3'h6, 1'b0, 1'b0}, '{12'h5DC, 12'h000, 3'h5, 1'b0, 1'b0},
    '{12'h640, 12'h000, 3'h4, 1'b0, 1'b0}, '{12'h6A4, 12'h000, 3'h3, 1'b0, 1'b0},
    '{12'h708, 12'h000, 3'h2, 1'b0, 1'b0}, '{12'h7D0, 12'h000, 3'h1, 1'b0, 1'b0},
    '{12'h18F, 12'h000, 3'h6, 1'b1, 1'b1}, '{12'h1C2, 12'h000, 3'h6, 1'b1, 1'b1},
    '{12'h1C3, 12'h000, 3'h6, 1'b1, 1'b0}, '{12'h2BC, 12'h258, 3'h6, 1'b1, 1'b0},
    '{12'h321, 12'h258, 3'h6, 1'b0, 1'b0}, '{12'h257, 12'h258, 3'h6, 1'b1, 1'b0},
    '{12'h5DC, 12'h000, 3'h5, 1'b0, 1'b0}};
  vlfc_mv_t  vfb [6] = '{12'h834, 12'h514, 12'h47E, 12'h41A, 12'h3B6, 12'h352};
  vlfc_smv_t oppv [2] = '{12'hF06, 12'h064};
  vlfc_mv_t  oppx [2] = '{12'h226, 12'h320};

  vlfc_sched dut (.CLK(clk), .SRST(srst), .FEEDBACK_LEVEL(fb), .FOLDBACK_ADJUST_LEVEL(adj),
    .FOLDBACK_ADJUST_INPUT(adj_en), .OVERPOWER_COMP_VOLTAGE(overpower_comp_input), .ON_TIME(on_time),
    .DEMAG_DETECT(demag_detect), .DEMAG_DONE(demag_done), .GATE_DRIVE_OUT(gate),
    .VALLEY_LOCK_MODE(lock_mode), .FREQ_FOLDBACK_MODE(ff_mode), .SKIP_ACTIVE(skip),
    .SELECTED_VALLEY(valley), .COMPENSATED_PEAK_SETPOINT(setpt));
  vlfc_gate_partner far (.clk(clk), .srst(srst), .gate(gate), .dem_cyc(dem_cyc),
    .gap_cyc(gap_cyc), .n_valleys(n_val), .on_time(on_time), .demag_detect(demag_detect),
    .demag_done(demag_done));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_rng

  // gate-to-gate length, valleys seen and clocks from the last valley
  task automatic period(input int bound);
    per   = 0;
    nv    = 0;
    since = 0;
    do begin
      @(negedge clk);
      per++;
      since++;
      if (demag_detect === 1'b1) begin
        nv++;
        since = 0;
      end
      if (per > bound) begin
        mismatches++;
        $display("Error gate pulse expected within %0d seen none", bound);
        close_out();
      end
    end while (gate !== 1'b1);
  endtask : period

  // expected setpoint: quarter of feedback, floor, freeze and cap
  function automatic vlfc_mv_t exp_set(vlfc_mv_t f, vlfc_mv_t a, logic ff);
    vlfc_mv_t v;
    v = f >> 2;
    if (ff && a != 12'h000) v = a >> 2;
    else if (v < `VLFC_SET_MIN) v = `VLFC_SET_MIN;
    if (v > `VLFC_ILIM1) v = `VLFC_ILIM1;
    return v;
  endfunction : exp_set

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check("gate", 12'h000, 12'(gate));
    check("lock", 12'h001, 12'(lock_mode));
    check("foldback", 12'h000, 12'(ff_mode));
    check("skip", 12'h001, 12'(skip));
    check("valley", 12'h001, 12'(valley));
    check("setpoint", `VLFC_SET_MIN, setpt);
    @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset

  // main sequence
  initial begin
    srst = 1'b1;
    fb = 12'h834;
    adj = 12'h000;
    adj_en = 1'b0;
    overpower_comp_input = 12'h000;
    dem_cyc = 16'h0028;
    gap_cyc = 16'h0014;
    n_val = 16'h0008;
    mismatches = 0;
    comparisons = 0;
    do_reset();
    foreach (rows[i]) begin
      @(posedge clk);
      fb <= rows[i].fb;
      adj <= rows[i].adj;
      adj_en <= (rows[i].adj != 12'h000);
      repeat (12) @(negedge clk);
      check("valley", 12'(rows[i].v), 12'(valley));
      check("foldback", 12'(rows[i].ff), 12'(ff_mode));
      check("lock", 12'(!rows[i].ff), 12'(lock_mode));
      check("skip", 12'(rows[i].sk), 12'(skip));
      check("setpoint", exp_set(rows[i].fb, rows[i].adj, rows[i].ff), setpt);
    end
    // next-edge latency, then one valley step per clock
    @(posedge clk);
    fb <= 12'h383;
    @(negedge clk);
    check("valley", 12'h005, 12'(valley));
    @(negedge clk);
    check("valley", 12'h006, 12'(valley));
    @(posedge clk);
    fb <= 12'h834;
    for (int i = 6; i >= 4; i--) begin
      @(negedge clk);
      check("valley", 12'(i), 12'(valley));
    end
    // drive on the selected valley, one clock after it
    for (int v = 0; v < 6; v++) begin
      @(posedge clk);
      fb <= vfb[v];
      period(2500);
      period(2500);
      check_rng("valleys", v + 1, v + 1, nv);
      check_rng("valley to drive", 1, 1, since);
    end
    // damped ringing: expired timeouts stand in for valleys
    @(posedge clk);
    n_val <= 16'h0002;
    period(2500);
    period(2500);
    check_rng("timeout drive", 4 * `VLFC_TOUT_CYC - 2, 4 * `VLFC_TOUT_CYC + 4, since);
    n_val <= 16'h0006;
    // foldback dead-time after the sixth valley
    foreach (vfb[i]) begin
      if (i < 2) begin
        @(posedge clk);
        fb <= (i == 0) ? 12'h316 : 12'h258;
        period(2500);
        period(2500);
        d = int'(fb) - 400;
        n = (`VLFC_DEAD_CYC * 400 + d - 1) / d;
        check_rng("valleys", 6, 6, nv);
        check_rng("dead time", n, n + 3, since);
      end
    end
    // minimum-frequency clamp, and its wait for demagnetization
    @(posedge clk);
    fb <= 12'h19A;
    period(2500);
    period(2500);
    check_rng("clamp period", `VLFC_CLAMP_CYC - 1, `VLFC_CLAMP_CYC + 3, per);
    dem_cyc <= 16'h09C4;
    period(3000);
    period(3000);
    check_rng("clamp after demag", 2510, 2515, per);
    dem_cyc <= 16'h0028;
    // skip mode stops and restarts drive pulses
    @(posedge clk);
    fb <= 12'h18F;
    repeat (3) @(negedge clk);
    n = 0;
    repeat (2500) begin
      @(negedge clk);
      if (gate === 1'b1) n++;
    end
    check_rng("pulses in skip", 0, 0, n);
    @(posedge clk);
    fb <= 12'h1C3;
    period(2600);
    check("skip", 12'h000, 12'(skip));
    // over-power compensation during the on-time, cap at all times
    @(posedge clk);
    fb <= 12'hE10;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      overpower_comp_input <= oppv[i];
      n = 0;
      do begin
        @(negedge clk);
        n++;
        if (n > 3000) begin
          mismatches++;
          $display("Error on-time expected seen none");
          close_out();
        end
      end while (on_time !== 1'b1);
      repeat (3) @(negedge clk);
      check("on-time setpoint", oppx[i], setpt);
      repeat (12) @(negedge clk);
      check("off-time setpoint", `VLFC_ILIM1, setpt);
    end
    do_reset();
    close_out();
  end
endmodule : tb_top
